//--- dv/hci_uart_monitor.sv
// Assertion checker watching the serial link between the two ends.
`timescale 1ns/1ps
module hci_uart_monitor (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	// Link lines.
	input wire logic dev_txd,
	input wire logic host_txd,
	input wire logic dev_rts,
	input wire logic host_rts
);
	localparam int HALF = 8; // Mid-bit offset at the bench rate of 16 cycles a bit.
	localparam int FRAME = 160; // One 8N1 character in cycles.
	logic [7:0] dfc_q; // Cycles left in the device character.
	logic [7:0] hfc_q; // Cycles left in the host character.
	logic [7:0] cts_q; // Cycles the host has held its stop request.
	logic [7:0] rts_q; // Cycles the device has held its stop request.
	wire dstart = dfc_q == 8'h00 && !dev_txd; // A device start bit begins.
	wire hstart = hfc_q == 8'h00 && !host_txd; // A host start bit begins.
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RESET_N);
	////////////////////////////////////////////////////////////////////////////////
	// Run counters saturate, so a long pause cannot wrap them back under the limit.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			dfc_q <= 8'h00;
			hfc_q <= 8'h00;
			cts_q <= 8'h00;
			rts_q <= 8'h00;
		end else begin
			dfc_q <= dstart ? 8'(FRAME - 1) : dfc_q - {7'h00, dfc_q != 8'h00};
			hfc_q <= hstart ? 8'(FRAME - 1) : hfc_q - {7'h00, hfc_q != 8'h00};
			cts_q <= host_rts ? cts_q + {7'h00, cts_q != 8'hff} : 8'h00;
			rts_q <= dev_rts ? rts_q + {7'h00, rts_q != 8'hff} : 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_dlow; $fell(dev_txd) |-> !dev_txd [*8]; endproperty
	property p_dhigh; $rose(dev_txd) |-> dev_txd [*8]; endproperty
	property p_hlow; $fell(host_txd) |-> (!host_txd) throughout (1'b1 ##HALF 1'b1); endproperty
	property p_dstop; dfc_q == 8'(HALF) |-> dev_txd; endproperty
	property p_hstop; hfc_q == 8'(HALF) |-> host_txd; endproperty
	property p_cts; dstart |-> cts_q < 8'h06; endproperty
	property p_hold; hstart |-> rts_q < 8'h06; endproperty
	property p_rts; $rose(dev_rts) |-> host_txd; endproperty
	a_dlow: assert property (p_dlow) else $error("device low bit too short");
	a_dhigh: assert property (p_dhigh) else $error("device high bit too short");
	a_hlow: assert property (p_hlow) else $error("host low bit too short");
	a_dstop: assert property (p_dstop) else $error("device stop bit missing");
	a_hstop: assert property (p_hstop) else $error("host stop bit missing");
	a_cts: assert property (p_cts) else $error("device started while held");
	a_hold: assert property (p_hold) else $error("host started while held");
	a_rts: assert property (p_rts) else $error("request rose outside stop bit");
	c_dstart: cover property (dstart);
	c_cts: cover property (host_rts && dfc_q != 8'h00);
	c_rts: cover property ($rose(dev_rts));
endmodule : hci_uart_monitor

//--- dv/tb_hci_uart_transport.sv
// Self-checking bench joining the controller end and the host end over one link.
`timescale 1ns/1ps
module tb_hci_uart_transport;
	logic mclk = 1'b0; // System clock.
	logic reset_n = 1'b0; // Active-low reset.
	logic [4:0] addr = 5'h00; // Register bus request lines.
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wait_req;
	logic irq;
	logic mode_h5 = 1'b0; // Host configuration.
	logic pause = 1'b0;
	logic [7:0] htx = 8'h00; // Host byte streams.
	logic htx_valid = 1'b0;
	logic htx_ready;
	logic [7:0] hrx;
	logic hrx_valid;
	logic [7:0] rxq[$]; // Bytes the host has received.
	logic [31:0] v; // Last read data.
	int fail_count = 0;
	int cmp_count = 0;
	hci_link_if hci_link_if_inst ();
	hci_uart_device hci_uart_device_inst (.I_MCLK(mclk), .I_RESET_N(reset_n),
		.I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req), .O_IRQ(irq),
		.link(hci_link_if_inst.device));
	hci_uart_host hci_uart_host_inst (.I_MCLK(mclk), .I_RESET_N(reset_n),
		.I_MODE_H5(mode_h5), .I_DIVISOR(16'h0010), .I_PAUSE(pause), .I_TX_DATA(htx),
		.I_TX_VALID(htx_valid), .O_TX_READY(htx_ready), .O_RX_DATA(hrx),
		.O_RX_VALID(hrx_valid), .link(hci_link_if_inst.host));
	hci_uart_monitor hci_uart_monitor_inst (.I_MCLK(mclk), .I_RESET_N(reset_n),
		.dev_txd(hci_link_if_inst.dev_txd), .host_txd(hci_link_if_inst.host_txd),
		.dev_rts(hci_link_if_inst.dev_rts), .host_rts(hci_link_if_inst.host_rts));
	// The clock runs steady from time zero, long before reset lets go.
	always #10 mclk = ~mclk;
	// The received-byte pulse lasts one cycle, so it is caught on every edge.
	always @(posedge mclk) if (hrx_valid === 1'b1) rxq.push_back(hrx);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wcyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : wcyc
	// One bus cycle; the request stands until the rising edge that sees waitrequest low.
	// Only the watchdog ends a wait that never finishes.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do @(posedge mclk); while (wait_req !== 1'b0);
		v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk);
	endtask : bus
	task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(v, exp);
	endtask : rchk
	task automatic chkq(input logic [7:0] b);
		chk(rxq.size() != 0 ? {24'h0, rxq.pop_front()} : 32'hx, {24'h0, b});
	endtask : chkq
	task automatic hsend(input logic [7:0] b);
		htx <= b;
		htx_valid <= 1'b1;
		do @(posedge mclk); while (htx_ready !== 1'b1);
		htx_valid <= 1'b0;
		@(posedge mclk);
	endtask : hsend
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		wcyc(16);
		reset_n <= 1'b1;
		wcyc(1);
		rchk(hci_uart_pkg::REG_CTRL, 32'(hci_uart_pkg::CTRL_RESET));
		rchk(hci_uart_pkg::REG_DIV, 32'(hci_uart_pkg::DIV_DEFAULT));
		rchk(5'h1c, 32'h0);
		bus(1'b1, hci_uart_pkg::REG_DIV, 32'h5);
		rchk(hci_uart_pkg::REG_DIV, 32'(hci_uart_pkg::DIV_MIN));
		bus(1'b1, hci_uart_pkg::REG_DIV, 32'h10);
		rchk(hci_uart_pkg::REG_DIV, 32'h10);
		$display("test reset_and_rate done");
		bus(1'b1, hci_uart_pkg::REG_MASK, 32'h40);
		hsend(8'h42);
		wcyc(400);
		chk({31'h0, irq}, 32'h1);
		rchk(hci_uart_pkg::REG_INFO, 32'h101);
		rchk(hci_uart_pkg::REG_RXDATA, 32'h142);
		rchk(hci_uart_pkg::REG_STATUS, 32'hc2);
		bus(1'b1, hci_uart_pkg::REG_STATUS, 32'hff);
		chk({31'h0, irq}, 32'h0);
		$display("test detect_and_irq done");
		bus(1'b1, hci_uart_pkg::REG_CTRL, 32'h8);
		bus(1'b1, hci_uart_pkg::REG_TXDATA, 32'ha5);
		bus(1'b1, hci_uart_pkg::REG_TXDATA, 32'h3c);
		wcyc(400);
		chkq(8'ha5);
		chkq(8'h3c);
		bus(1'b0, hci_uart_pkg::REG_STATUS, 32'h0);
		chk(v & 32'h20, 32'h20);
		bus(1'b1, hci_uart_pkg::REG_CTRL, 32'h0);
		$display("test transmit done");
		bus(1'b1, hci_uart_pkg::REG_TXDATA, 32'h81);
		wcyc(40);
		pause <= 1'b1;
		bus(1'b1, hci_uart_pkg::REG_TXDATA, 32'h7e);
		wcyc(500);
		chkq(8'h81);
		chk(rxq.size(), 32'h0);
		pause <= 1'b0;
		wcyc(400);
		chkq(8'h7e);
		$display("test clear_to_send done");
		fork
			for (int i = 0; i < 14; i++) hsend(8'(8'h20 + i));
		join_none
		wcyc(2600);
		chk({31'h0, hci_link_if_inst.dev_rts}, 32'h1);
		rchk(hci_uart_pkg::REG_INFO, 32'hc05);
		for (int i = 0; i < 14; i++) begin
			if (i == 12) wcyc(500);
			rchk(hci_uart_pkg::REG_RXDATA, 32'(32'h120 + i));
		end
		chk({31'h0, hci_link_if_inst.dev_rts}, 32'h0);
		bus(1'b1, hci_uart_pkg::REG_CTRL, 32'h4);
		chk({31'h0, hci_link_if_inst.dev_rts}, 32'h1);
		bus(1'b1, hci_uart_pkg::REG_CTRL, 32'h0);
		chk({31'h0, hci_link_if_inst.dev_rts}, 32'h0);
		$display("test request_to_send done");
		reset_n <= 1'b0;
		mode_h5 <= 1'b1;
		wcyc(4);
		reset_n <= 1'b1;
		wcyc(1);
		bus(1'b1, hci_uart_pkg::REG_DIV, 32'h10);
		hsend(hci_uart_pkg::CHAR_H5_DELIM);
		wcyc(300);
		bus(1'b0, hci_uart_pkg::REG_INFO, 32'h0);
		chk(v & 32'h3, 32'h3);
		pause <= 1'b1;
		wcyc(300);
		bus(1'b1, hci_uart_pkg::REG_TXDATA, 32'h55);
		wcyc(400);
		chk(rxq.size(), 32'h0);
		bus(1'b0, hci_uart_pkg::REG_INFO, 32'h0);
		chk(v & 32'h10, 32'h10);
		pause <= 1'b0;
		wcyc(400);
		chkq(8'h55);
		$display("test three_wire done");
		wrap_up();
	end
	// A hang counts as a mismatch and ends the run in the same place.
	initial begin
		wcyc(20000);
		fail_count++;
		wrap_up();
	end
endmodule : tb_hci_uart_transport

//--- hw/hci_uart_device.sv
// Controller end of the host serial transport with an Avalon-MM register slave.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - One serial port carries commands, events, data.
// - Four-wire mode: flow lines checked every byte.
// - Three-wire mode uses XON/XOFF in-band characters.
// - Protocol chosen from first received byte.
// - Starts at 115.2 kbps, up to 4 Mbps.
// - New rate applies after pending event drains.
// - Flags break, idle, framing, overflow, parity, underflow.
// - Default eight data bits, one stop, no parity.
// - Request-to-send high when receive buffer passes threshold.
// - No new byte starts while clear-to-send high.
// - Byte in flight completes before stopping.
// - Sleep handshake carried on flow-control lines.
// - Three-wire mode pauses peer with XOFF, resumes XON.
// - Slow clock stable 64 cycles after release; this design has no slow clock input.
module hci_uart_device #(
	parameter int DEPTH = 16,
	parameter int THRESH = 12
) (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	// Avalon-MM slave.
	input wire logic [4:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// Interrupt.
	output logic O_IRQ,
	// Serial link.
	hci_link_if.device link
);
	localparam int AW = $clog2(DEPTH);

	// Registers written by software.
	logic [3:0] ctrl_q;
	logic [15:0] div_q, div_pend_q;
	logic sw_pend_q;
	logic [hci_uart_pkg::ST_W-1:0] stat_q, mask_q, ev;
	// Protocol state.
	logic detected_q, h5_q, paused_q;
	// Synchronisers for the incoming lines.
	logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q;
	// Receiver.
	hci_uart_pkg::rx_state_t rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_par_bad_q;
	logic [19:0] idle_cnt_q;
	logic idle_arm_q;
	// Receive buffer.
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] fill_q;
	// Transmitter.
	hci_uart_pkg::tx_state_t tx_st_q;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_left_q;
	logic [15:0] tx_cnt_q;
	logic txd_q, txh_v_q;
	logic [7:0] txh_q;
	// Flow-control character waiting to go out in three-wire mode.
	logic fc_v_q, fc_char_off_q, above_q;
	// Bus side.
	logic rack_q;
	logic [31:0] rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Decode.

	wire rx_line = rx_s2_q;
	wire cts_line = cts_s2_q;
	wire rx_tick = (rx_cnt_q == 16'h0000);
	wire [7:0] rx_byte = rx_sh_q;
	wire byte_done = (rx_st_q == hci_uart_pkg::RX_STOP) && rx_tick && rx_line;
	wire is_fc = h5_q && detected_q &&
		(rx_byte == hci_uart_pkg::CHAR_XON || rx_byte == hci_uart_pkg::CHAR_XOFF);
	wire full = (fill_q == (AW+1)'(DEPTH));
	// The first byte is kept too: it opens the command that chose the protocol.
	wire push = byte_done && !is_fc && !full;
	wire first = byte_done && !detected_q;
	wire wr_ok = I_AVS_WRITE && !O_AVS_WAITREQUEST;
	wire pop = I_AVS_READ && rack_q && (I_AVS_ADDRESS == hci_uart_pkg::REG_RXDATA) &&
		(fill_q != '0);
	wire above = (fill_q >= (AW+1)'(THRESH));
	// Four-wire mode, and the undecided start, obey clear-to-send; three-wire obeys XOFF.
	wire blocked = (detected_q && h5_q) ? paused_q : cts_line;
	wire tx_idle = (tx_st_q == hci_uart_pkg::TX_IDLE);
	wire start_fc = tx_idle && fc_v_q;
	wire start_usr = tx_idle && !fc_v_q && txh_v_q && !blocked;
	wire tx_tick = (tx_cnt_q == 16'h0000);
	wire tx_last = (tx_st_q == hci_uart_pkg::TX_SEND) && tx_tick && (tx_left_q == 4'h1);
	// Byte carried by the next frame; a pending flow character goes ahead of user data.
	wire [7:0] tx_char = start_fc ?
		(fc_char_off_q ? hci_uart_pkg::CHAR_XOFF : hci_uart_pkg::CHAR_XON) : txh_q;
	// Four-wire request-to-send also held high while software asks for sleep.
	assign link.dev_rts = !(detected_q && h5_q) &&
		(above || ctrl_q[hci_uart_pkg::CTRL_SLEEP]);
	assign link.dev_txd = txd_q;
	assign O_IRQ = |(stat_q & mask_q);
	assign O_AVS_READDATA = rdata_q;
	// Reads take one wait cycle; a transmit write waits while the holding byte is full.
	assign O_AVS_WAITREQUEST = (I_AVS_READ && !rack_q) ||
		(I_AVS_WRITE && I_AVS_ADDRESS == hci_uart_pkg::REG_TXDATA && txh_v_q);

	// Events that set sticky status bits.
	always_comb begin
		ev = '0;
		ev[hci_uart_pkg::ST_BREAK] = (rx_st_q == hci_uart_pkg::RX_STOP) && rx_tick &&
			!rx_line && (rx_byte == 8'h00);
		ev[hci_uart_pkg::ST_FRAME] = (rx_st_q == hci_uart_pkg::RX_STOP) && rx_tick &&
			!rx_line && (rx_byte != 8'h00);
		ev[hci_uart_pkg::ST_PARITY] = byte_done && rx_par_bad_q;
		ev[hci_uart_pkg::ST_OVERFLOW] = byte_done && !is_fc && full;
		ev[hci_uart_pkg::ST_IDLE] = idle_arm_q &&
			(idle_cnt_q == 20'(div_q) * 20'(hci_uart_pkg::IDLE_BITS));
		ev[hci_uart_pkg::ST_UNDERFLOW] = tx_last && !txh_v_q && ctrl_q[hci_uart_pkg::CTRL_BURST];
		ev[hci_uart_pkg::ST_DETECTED] = first;
		ev[hci_uart_pkg::ST_RATE] = sw_pend_q && tx_idle && !txh_v_q && !fc_v_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers, rate switch and interrupt status.

	// A new divisor only waits; it takes over once the transmitter has drained.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl_q <= hci_uart_pkg::CTRL_RESET;
			div_q <= hci_uart_pkg::DIV_DEFAULT;
			div_pend_q <= hci_uart_pkg::DIV_DEFAULT;
			sw_pend_q <= 1'b0;
			mask_q <= '0;
			stat_q <= '0;
		end else begin
			if (wr_ok && I_AVS_ADDRESS == hci_uart_pkg::REG_CTRL) ctrl_q <= I_AVS_WRITEDATA[3:0];
			if (wr_ok && I_AVS_ADDRESS == hci_uart_pkg::REG_MASK) mask_q <= I_AVS_WRITEDATA[7:0];
			if (wr_ok && I_AVS_ADDRESS == hci_uart_pkg::REG_DIV) begin
				// Divisors below the fastest legal rate are raised to it.
				div_pend_q <= (I_AVS_WRITEDATA[15:0] < hci_uart_pkg::DIV_MIN) ?
					hci_uart_pkg::DIV_MIN : I_AVS_WRITEDATA[15:0];
				sw_pend_q <= 1'b1;
			end else if (ev[hci_uart_pkg::ST_RATE]) begin
				div_q <= div_pend_q;
				sw_pend_q <= 1'b0;
			end
			// Set wins over a same-cycle clear.
			stat_q <= (stat_q & ~((wr_ok && I_AVS_ADDRESS == hci_uart_pkg::REG_STATUS) ?
				I_AVS_WRITEDATA[7:0] : 8'h00)) | ev;
		end
	end

	// Read data is captured during the wait cycle.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			rack_q <= I_AVS_READ && !rack_q;
			if (I_AVS_READ && !rack_q) begin
				case (I_AVS_ADDRESS)
					hci_uart_pkg::REG_CTRL: rdata_q <= {28'h0, ctrl_q};
					hci_uart_pkg::REG_DIV: rdata_q <= {16'h0, div_q};
					hci_uart_pkg::REG_STATUS: rdata_q <= {24'h0, stat_q};
					hci_uart_pkg::REG_MASK: rdata_q <= {24'h0, mask_q};
					hci_uart_pkg::REG_RXDATA: rdata_q <= {23'h0, fill_q != '0, mem[rp_q]};
					hci_uart_pkg::REG_INFO: rdata_q <= 32'({fill_q, 3'b000, paused_q, cts_line,
						link.dev_rts, h5_q, detected_q});
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line synchronisers and protocol detection.

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			{rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q} <= 4'hf;
			detected_q <= 1'b0;
			h5_q <= 1'b0;
			paused_q <= 1'b0;
		end else begin
			rx_s1_q <= link.host_txd;
			rx_s2_q <= rx_s1_q;
			cts_s1_q <= link.host_rts;
			cts_s2_q <= cts_s1_q;
			// A leading slip delimiter marks three-wire; anything else is four-wire.
			if (first) begin
				detected_q <= 1'b1;
				h5_q <= (rx_byte == hci_uart_pkg::CHAR_H5_DELIM);
			end
			if (byte_done && is_fc) paused_q <= (rx_byte == hci_uart_pkg::CHAR_XOFF);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver: samples mid-bit, LSB first, optional parity.

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rx_st_q <= hci_uart_pkg::RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_par_bad_q <= 1'b0;
		end else begin
			rx_cnt_q <= rx_tick ? (div_q - 16'h0001) : (rx_cnt_q - 16'h0001);
			case (rx_st_q)
				hci_uart_pkg::RX_IDLE: begin
					rx_par_bad_q <= 1'b0;
					if (!rx_line) begin
						rx_cnt_q <= {1'b0, div_q[15:1]};
						rx_st_q <= hci_uart_pkg::RX_START;
					end
				end
				hci_uart_pkg::RX_START: begin
					// A glitch shorter than half a bit is dropped.
					if (rx_tick) rx_st_q <= rx_line ? hci_uart_pkg::RX_IDLE : hci_uart_pkg::RX_DATA;
					rx_bit_q <= 3'h0;
				end
				hci_uart_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_sh_q <= {rx_line, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7) rx_st_q <= ctrl_q[hci_uart_pkg::CTRL_PAR_EN] ?
							hci_uart_pkg::RX_PAR : hci_uart_pkg::RX_STOP;
					end
				end
				hci_uart_pkg::RX_PAR: begin
					if (rx_tick) begin
						rx_par_bad_q <= (^rx_sh_q ^ ctrl_q[hci_uart_pkg::CTRL_PAR_ODD]) != rx_line;
						rx_st_q <= hci_uart_pkg::RX_STOP;
					end
				end
				hci_uart_pkg::RX_STOP: begin
					if (rx_tick) rx_st_q <= hci_uart_pkg::RX_IDLE;
				end
				default: rx_st_q <= hci_uart_pkg::RX_IDLE;
			endcase
		end
	end

	// Idle is reported once per quiet spell after some traffic.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			idle_cnt_q <= 20'h00000;
			idle_arm_q <= 1'b0;
		end else if (rx_st_q != hci_uart_pkg::RX_IDLE || !rx_line) begin
			idle_cnt_q <= 20'h00000;
			idle_arm_q <= 1'b1;
		end else begin
			idle_cnt_q <= idle_cnt_q + 20'h00001;
			if (ev[hci_uart_pkg::ST_IDLE]) idle_arm_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive buffer and three-wire flow characters.

	always_ff @(posedge I_MCLK) begin
		if (push) mem[wp_q] <= rx_byte;
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			wp_q <= '0;
			rp_q <= '0;
			fill_q <= '0;
			above_q <= 1'b0;
			fc_v_q <= 1'b0;
			fc_char_off_q <= 1'b0;
		end else begin
			if (push) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (pop) rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
			above_q <= above;
			// Crossing the threshold queues XOFF, dropping back queues XON.
			if (detected_q && h5_q && above != above_q) begin
				fc_v_q <= 1'b1;
				fc_char_off_q <= above;
			end else if (start_fc) fc_v_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter: a byte once started always runs to its stop bit.

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tx_st_q <= hci_uart_pkg::TX_IDLE;
			tx_sh_q <= 11'h7ff;
			tx_left_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
			txd_q <= 1'b1;
			txh_v_q <= 1'b0;
			txh_q <= 8'h00;
		end else begin
			if (wr_ok && I_AVS_ADDRESS == hci_uart_pkg::REG_TXDATA) begin
				txh_q <= I_AVS_WRITEDATA[7:0];
				txh_v_q <= 1'b1;
			end else if (start_usr) txh_v_q <= 1'b0;
			if (start_fc || start_usr) begin
				// Frame is start, eight data LSB first, optional parity, stop.
				// Parity covers the byte actually sent, flow characters included.
				tx_sh_q <= ctrl_q[hci_uart_pkg::CTRL_PAR_EN] ?
					{1'b1, ^tx_char ^ ctrl_q[hci_uart_pkg::CTRL_PAR_ODD], tx_char, 1'b0} :
					{2'b11, tx_char, 1'b0};
				tx_left_q <= ctrl_q[hci_uart_pkg::CTRL_PAR_EN] ? 4'hb : 4'ha;
				tx_cnt_q <= 16'h0000;
				tx_st_q <= hci_uart_pkg::TX_SEND;
			end else if (tx_st_q == hci_uart_pkg::TX_SEND) begin
				// Clear-to-send is not looked at here, so a byte is never cut short.
				tx_cnt_q <= tx_tick ? (div_q - 16'h0001) : (tx_cnt_q - 16'h0001);
				if (tx_tick) begin
					txd_q <= tx_sh_q[0];
					tx_sh_q <= {1'b1, tx_sh_q[10:1]};
					tx_left_q <= tx_left_q - 4'h1;
				end
				if (tx_tick && tx_left_q == 4'h0) tx_st_q <= hci_uart_pkg::TX_IDLE;
			end else begin
				txd_q <= 1'b1;
			end
		end
	end
endmodule : hci_uart_device

//--- hw/hci_uart_host.sv
// Host end of the serial transport: byte streams in and out with flow control.
`timescale 1ns/1ps
module hci_uart_host (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	// Configuration.
	input wire logic I_MODE_H5,
	input wire logic [15:0] I_DIVISOR,
	input wire logic I_PAUSE,
	// Transmit stream.
	input wire logic [7:0] I_TX_DATA,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	// Receive stream.
	output logic [7:0] O_RX_DATA,
	output logic O_RX_VALID,
	// Serial link.
	hci_link_if.host link
);
	// Line synchronisers.
	logic rx_s1_q, rx_s2_q, rts_s1_q, rts_s2_q;
	// Receiver.
	hci_uart_pkg::rx_state_t rx_st_q;
	logic [15:0] rx_cnt_q, div_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q, rxd_q;
	logic rxv_q, paused_q, pause_q, fc_v_q;
	// Transmitter.
	hci_uart_pkg::tx_state_t tx_st_q;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_left_q;
	logic [15:0] tx_cnt_q;
	logic txd_q;

	////////////////////////////////////////////////////////////////////////
	// Decode.

	wire rx_tick = (rx_cnt_q == 16'h0000);
	wire tx_tick = (tx_cnt_q == 16'h0000);
	wire byte_done = (rx_st_q == hci_uart_pkg::RX_STOP) && rx_tick && rx_s2_q;
	wire is_fc = I_MODE_H5 &&
		(rx_sh_q == hci_uart_pkg::CHAR_XON || rx_sh_q == hci_uart_pkg::CHAR_XOFF);
	wire tx_idle = (tx_st_q == hci_uart_pkg::TX_IDLE);
	// Host stops new bytes while the controller asks it to.
	wire blocked = I_MODE_H5 ? paused_q : rts_s2_q;
	wire start_fc = tx_idle && fc_v_q;
	assign O_TX_READY = tx_idle && !fc_v_q && !blocked;
	wire start_usr = O_TX_READY && I_TX_VALID;
	assign link.host_txd = txd_q;
	assign link.host_rts = !I_MODE_H5 && I_PAUSE;
	assign O_RX_DATA = rxd_q;
	assign O_RX_VALID = rxv_q;

	////////////////////////////////////////////////////////////////////////
	// Receiver and incoming flow characters.

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			{rx_s1_q, rx_s2_q, rts_s1_q, rts_s2_q} <= 4'hf;
			rx_st_q <= hci_uart_pkg::RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rxd_q <= 8'h00;
			rxv_q <= 1'b0;
			paused_q <= 1'b0;
		end else begin
			rx_s1_q <= link.dev_txd;
			rx_s2_q <= rx_s1_q;
			rts_s1_q <= link.dev_rts;
			rts_s2_q <= rts_s1_q;
			rxv_q <= byte_done && !is_fc;
			if (byte_done && !is_fc) rxd_q <= rx_sh_q;
			if (byte_done && is_fc) paused_q <= (rx_sh_q == hci_uart_pkg::CHAR_XOFF);
			rx_cnt_q <= rx_tick ? (div_q - 16'h0001) : (rx_cnt_q - 16'h0001);
			case (rx_st_q)
				hci_uart_pkg::RX_IDLE: begin
					if (!rx_s2_q) begin
						rx_cnt_q <= {1'b0, div_q[15:1]};
						rx_st_q <= hci_uart_pkg::RX_START;
					end
				end
				hci_uart_pkg::RX_START: begin
					if (rx_tick) rx_st_q <= rx_s2_q ? hci_uart_pkg::RX_IDLE : hci_uart_pkg::RX_DATA;
					rx_bit_q <= 3'h0;
				end
				hci_uart_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7) rx_st_q <= hci_uart_pkg::RX_STOP;
					end
				end
				hci_uart_pkg::RX_STOP: begin
					if (rx_tick) rx_st_q <= hci_uart_pkg::RX_IDLE;
				end
				default: rx_st_q <= hci_uart_pkg::RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter with flow characters ahead of user bytes.

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			div_q <= hci_uart_pkg::DIV_DEFAULT;
			pause_q <= 1'b0;
			fc_v_q <= 1'b0;
			tx_st_q <= hci_uart_pkg::TX_IDLE;
			tx_sh_q <= 10'h3ff;
			tx_left_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
			txd_q <= 1'b1;
		end else begin
			// The new rate is taken only while both directions are quiet.
			if (tx_idle && rx_st_q == hci_uart_pkg::RX_IDLE) div_q <= I_DIVISOR;
			pause_q <= I_PAUSE;
			if (I_MODE_H5 && I_PAUSE != pause_q) fc_v_q <= 1'b1;
			else if (start_fc) fc_v_q <= 1'b0;
			if (start_fc || start_usr) begin
				tx_sh_q <= {1'b1, start_fc ? (pause_q ? hci_uart_pkg::CHAR_XOFF :
					hci_uart_pkg::CHAR_XON) : I_TX_DATA, 1'b0};
				tx_left_q <= 4'ha;
				tx_cnt_q <= 16'h0000;
				tx_st_q <= hci_uart_pkg::TX_SEND;
			end else if (tx_st_q == hci_uart_pkg::TX_SEND) begin
				tx_cnt_q <= tx_tick ? (div_q - 16'h0001) : (tx_cnt_q - 16'h0001);
				if (tx_tick) begin
					txd_q <= tx_sh_q[0];
					tx_sh_q <= {1'b1, tx_sh_q[9:1]};
					tx_left_q <= tx_left_q - 4'h1;
				end
				if (tx_tick && tx_left_q == 4'h0) tx_st_q <= hci_uart_pkg::TX_IDLE;
			end else begin
				txd_q <= 1'b1;
			end
		end
	end
endmodule : hci_uart_host

//--- shared/hci_link_if.sv
// Serial link between the controller end and the host end.
`timescale 1ns/1ps
interface hci_link_if;
	logic dev_txd; // Controller to host data line.
	logic host_txd; // Host to controller data line.
	logic dev_rts; // Controller request-to-send, high asks the host to stop.
	logic host_rts; // Host request-to-send, seen by the controller as clear-to-send.
	modport device (output dev_txd, output dev_rts, input host_txd, input host_rts);
	modport host (input dev_txd, input dev_rts, output host_txd, output host_rts);
endinterface : hci_link_if

//--- shared/hci_uart_pkg.sv
// Shared constants, register map and state types of the host serial transport.
package hci_uart_pkg;
	// System clock rate and line rates.
	localparam int CLK_HZ = 50000000;
	localparam int BAUD_DEFAULT = 115200;
	localparam int BAUD_MAX = 4000000;
	// Cycles per bit at the power-up rate, rounded to the nearest cycle.
	localparam logic [15:0] DIV_DEFAULT = 16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
	// Fewest cycles per bit, rounded up so the rate never passes the maximum.
	localparam logic [15:0] DIV_MIN = 16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
	// Bit times of quiet line that count as an idle line.
	localparam int IDLE_BITS = 10;
	// Special characters.
	localparam logic [7:0] CHAR_XON = 8'h11;
	localparam logic [7:0] CHAR_XOFF = 8'h13;
	localparam logic [7:0] CHAR_H5_DELIM = 8'hc0;
	// Register byte offsets.
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_DIV = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_MASK = 5'h0c;
	localparam logic [4:0] REG_TXDATA = 5'h10;
	localparam logic [4:0] REG_RXDATA = 5'h14;
	localparam logic [4:0] REG_INFO = 5'h18;
	// Control field positions.
	localparam int CTRL_PAR_EN = 0;
	localparam int CTRL_PAR_ODD = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_BURST = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Status and mask field positions.
	localparam int ST_BREAK = 0;
	localparam int ST_IDLE = 1;
	localparam int ST_FRAME = 2;
	localparam int ST_OVERFLOW = 3;
	localparam int ST_PARITY = 4;
	localparam int ST_UNDERFLOW = 5;
	localparam int ST_DETECTED = 6;
	localparam int ST_RATE = 7;
	localparam int ST_W = 8;
	// Info and receive data field positions.
	localparam int INFO_DETECTED = 0;
	localparam int INFO_H5 = 1;
	localparam int INFO_RTS = 2;
	localparam int INFO_CTS = 3;
	localparam int INFO_PAUSED = 4;
	localparam int INFO_FILL = 8;
	localparam int RXD_VALID = 8;
	// Receiver and transmitter states.
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_PAR = 5'b01000,
		RX_STOP = 5'b10000
	} rx_state_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;
endpackage : hci_uart_pkg
